/* common/mie_pkg.sv */
package mie_pkg;

    // Instruction word layout.
    localparam int WORD_W      = 14;
    localparam int OP_HI       = 13;
    localparam int OP_LO       = 10;
    localparam int UPD_SEL_BIT = 2;
    localparam int REL_SEL_BIT = 6;
    localparam int OFFSET_W    = 6;
    localparam int FILE_W      = 7;
    localparam int LIT_W       = 8;
    localparam int BANK_W      = 5;
    localparam int LATCH_W     = 7;
    localparam int PTR_W       = 16;
    localparam int DATA_W      = 8;
    localparam int MEM_AW      = 8;
    localparam int MEM_DEPTH   = 256;

    // Opcode field values.
    localparam logic [3:0] OP_IND_UPD = 4'h1;
    localparam logic [3:0] OP_IND_REL = 4'h2;
    localparam logic [3:0] OP_BANK    = 4'h3;
    localparam logic [3:0] OP_LATCH   = 4'h4;
    localparam logic [3:0] OP_LITERAL = 4'h5;
    localparam logic [3:0] OP_STORE   = 4'h6;

    // Pointer update codes.
    localparam logic [1:0] UPD_PRE_INC  = 2'h0;
    localparam logic [1:0] UPD_PRE_DEC  = 2'h1;
    localparam logic [1:0] UPD_POST_INC = 2'h2;
    localparam logic [1:0] UPD_POST_DEC = 2'h3;

    // File addresses that act as the indirect data ports.
    localparam logic [6:0] FILE_IND0 = 7'h00;
    localparam logic [6:0] FILE_IND1 = 7'h01;

    // Software register offsets.
    localparam logic [3:0] REG_ACC     = 4'h0;
    localparam logic [3:0] REG_BANK    = 4'h1;
    localparam logic [3:0] REG_LATCH   = 4'h2;
    localparam logic [3:0] REG_STATUS  = 4'h3;
    localparam logic [3:0] REG_PTR0_LO = 4'h4;
    localparam logic [3:0] REG_PTR0_HI = 4'h5;
    localparam logic [3:0] REG_PTR1_LO = 4'h6;
    localparam logic [3:0] REG_PTR1_HI = 4'h7;
    localparam logic [3:0] REG_IND0    = 4'h8;
    localparam logic [3:0] REG_IND1    = 4'h9;
    localparam int         ZERO_BIT    = 0;

    // Reset values.
    localparam logic [7:0]  ACC_RST   = 8'h00;
    localparam logic [4:0]  BANK_RST  = 5'h00;
    localparam logic [6:0]  LATCH_RST = 7'h00;
    localparam logic [15:0] PTR_RST   = 16'h0000;

endpackage

/* common/mie_mem_if.sv */
`timescale 1ns/1ps
interface mie_mem_if;
    logic       wrEn;
    logic [7:0] wrAddr;
    logic [7:0] wrData;
    logic [7:0] rdAddrA;
    logic [7:0] rdDataA;
    logic [7:0] rdAddrB;
    logic [7:0] rdDataB;

    modport ctrl (output wrEn, wrAddr, wrData, rdAddrA, rdAddrB,
                  input  rdDataA, rdDataB);
    modport mem  (input  wrEn, wrAddr, wrData, rdAddrA, rdAddrB,
                  output rdDataA, rdDataB);
endinterface

/* design/mie_data_mem.sv */
`timescale 1ns/1ps
// Data memory with one clocked write port and two combinational reads.
module mie_data_mem (
    input wire logic sys_clk,
    mie_mem_if.mem   port
);
    logic [mie_pkg::DATA_W-1:0] store [mie_pkg::MEM_DEPTH];

    assign port.rdDataA = store[port.rdAddrA];
    assign port.rdDataB = store[port.rdAddrB];

    always_ff @(posedge sys_clk) begin
        if (port.wrEn) begin
            store[port.wrAddr] <= port.wrData;
        end
    end
endmodule

/* design/mie_move_exec.sv */
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Indirect load copies the pointed-to register into the accumulator, updating zero.
// - Indirect load picks pointer by one bit; code 00/01/10/11 pre/post inc/dec.
// - Pre modes address pointer plus/minus one; every update mode writes back the step.
// - Relative mode addresses pointer plus signed offset -32..31; pointer unchanged.
// - Indirect data port has no storage; accesses go to the pointed-to register.
// - Pointers span 0000h to FFFFh and wrap modulo sixteen bits.
// - Bank load writes its 5-bit literal to bank select; flags unchanged.
// - Latch load writes its 7-bit literal to the pc high latch; flags unchanged.
// - Literal load writes the 8-bit literal to the accumulator in one cycle.
// - Unused literal bit positions of the literal load are ignored.
// - Store copies the accumulator to the 7-bit file address; flags unchanged.
module mie_move_exec (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        instrValid,
    input  wire logic [13:0] instrWord,
    input  wire logic [3:0]  busAddr,
    input  wire logic [7:0]  busWrData,
    input  wire logic        busWr,
    input  wire logic        busRd,
    output logic      [7:0]  busRdData,
    output logic      [7:0]  acc,
    output logic      [4:0]  bankSelect,
    output logic      [6:0]  pcHighLatch,
    output logic             zeroFlag,
    output logic             instrDone,
    output logic             instrIllegal
);

    // Steps a pointer by one in either direction, wrapping at 16 bits.
    function automatic logic [15:0] ptrStep(input logic [15:0] p,
                                            input logic        down);
        ptrStep = down ? p - 16'h0001 : p + 16'h0001;
    endfunction

    // True when a valid instruction carries the given opcode.
    function automatic logic opIs(input logic       v,
                                  input logic [3:0] f,
                                  input logic [3:0] code);
        opIs = v && f == code;
    endfunction

    // True when a bus strobe addresses the given register offset.
    function automatic logic busHit(input logic       s,
                                    input logic [3:0] a,
                                    input logic [3:0] off);
        busHit = s && a == off;
    endfunction

    // Maps a 16-bit data address onto the implemented memory.
    function automatic logic [7:0] memIndex(input logic [15:0] a);
        memIndex = a[7:0];
    endfunction

    mie_mem_if memBus ();

    mie_data_mem uMem (
        .sys_clk (sys_clk),
        .port    (memBus.mem)
    );

    logic [15:0] ptr0;
    logic [15:0] ptr1;

    // Instruction decode.
    wire [3:0] opField   = instrWord[mie_pkg::OP_HI:mie_pkg::OP_LO];
    wire       isIndUpd  = opIs(instrValid, opField, mie_pkg::OP_IND_UPD);
    wire       isIndRel  = opIs(instrValid, opField, mie_pkg::OP_IND_REL);
    wire       isBank    = opIs(instrValid, opField, mie_pkg::OP_BANK);
    wire       isLatch   = opIs(instrValid, opField, mie_pkg::OP_LATCH);
    wire       isLiteral = opIs(instrValid, opField, mie_pkg::OP_LITERAL);
    wire       isStore   = opIs(instrValid, opField, mie_pkg::OP_STORE);
    wire       isIndLoad = isIndUpd || isIndRel;
    wire       isKnown   = isIndLoad || isBank || isLatch || isLiteral
                           || isStore;

    // Pointer selection and update mode.
    wire       indSel = isIndRel ? instrWord[mie_pkg::REL_SEL_BIT]
                                 : instrWord[mie_pkg::UPD_SEL_BIT];
    wire [1:0] pointerUpdateCode = instrWord[1:0];
    wire       stepDown = pointerUpdateCode == mie_pkg::UPD_PRE_DEC
                          || pointerUpdateCode == mie_pkg::UPD_POST_DEC;
    wire       stepPre  = pointerUpdateCode == mie_pkg::UPD_PRE_INC
                          || pointerUpdateCode == mie_pkg::UPD_PRE_DEC;
    wire [15:0] selPtr     = indSel ? ptr1 : ptr0;
    wire [15:0] steppedPtr = ptrStep(selPtr, stepDown);

    // Signed offset, sign extended to pointer width.
    wire [5:0]  relOffset = instrWord[mie_pkg::OFFSET_W-1:0];
    wire [15:0] relExt    = {{10{relOffset[5]}}, relOffset};
    wire [15:0] relAddr   = selPtr + relExt;

    // Effective address of the indirect load.
    wire [15:0] effAddr = isIndRel ? relAddr
                        : stepPre  ? steppedPtr
                                   : selPtr;

    wire [7:0] loadData = memBus.rdDataA;
    wire       loadZero = loadData == 8'h00;

    // Literal fields; bits above each literal are ignored.
    wire [7:0] litAcc   = instrWord[mie_pkg::LIT_W-1:0];
    wire [4:0] litBank  = instrWord[mie_pkg::BANK_W-1:0];
    wire [6:0] litLatch = instrWord[mie_pkg::LATCH_W-1:0];
    wire [6:0] fileAddr = instrWord[mie_pkg::FILE_W-1:0];

    // Store target: indirect ports redirect through a pointer.
    wire storeInd0 = fileAddr == mie_pkg::FILE_IND0;
    wire storeInd1 = fileAddr == mie_pkg::FILE_IND1;
    wire [7:0] storeIndex =
        storeInd0 ? memIndex(ptr0)
      : storeInd1 ? memIndex(ptr1)
                  : {bankSelect[0], fileAddr};

    // Software bus decode.
    wire wrAcc    = busHit(busWr, busAddr, mie_pkg::REG_ACC);
    wire wrBank   = busHit(busWr, busAddr, mie_pkg::REG_BANK);
    wire wrLatch  = busHit(busWr, busAddr, mie_pkg::REG_LATCH);
    wire wrStatus = busHit(busWr, busAddr, mie_pkg::REG_STATUS);
    wire wrP0Lo   = busHit(busWr, busAddr, mie_pkg::REG_PTR0_LO);
    wire wrP0Hi   = busHit(busWr, busAddr, mie_pkg::REG_PTR0_HI);
    wire wrP1Lo   = busHit(busWr, busAddr, mie_pkg::REG_PTR1_LO);
    wire wrP1Hi   = busHit(busWr, busAddr, mie_pkg::REG_PTR1_HI);
    wire wrInd0   = busHit(busWr, busAddr, mie_pkg::REG_IND0);
    wire wrInd1   = busHit(busWr, busAddr, mie_pkg::REG_IND1);
    wire busIndSel = busAddr == mie_pkg::REG_IND1;

    // Memory port connections; an instruction store wins the write port.
    assign memBus.rdAddrA = memIndex(effAddr);
    assign memBus.rdAddrB = memIndex(busIndSel ? ptr1 : ptr0);
    assign memBus.wrEn    = isStore || wrInd0 || wrInd1;
    assign memBus.wrAddr  = isStore ? storeIndex
                          : memIndex(wrInd1 ? ptr1 : ptr0);
    assign memBus.wrData  = isStore ? acc : busWrData;

    // Next accumulator; instructions take priority over software.
    wire [7:0] next_acc =
        isIndLoad ? loadData
      : isLiteral ? litAcc
      : wrAcc     ? busWrData
                  : acc;

    // Zero flag moves only with the indirect load or a software status write.
    wire next_zeroFlag =
        isIndLoad ? loadZero
      : wrStatus  ? busWrData[mie_pkg::ZERO_BIT]
                  : zeroFlag;

    wire [4:0] next_bankSelect =
        isBank ? litBank
      : wrBank ? busWrData[4:0]
               : bankSelect;

    wire [6:0] next_pcHighLatch =
        isLatch ? litLatch
      : wrLatch ? busWrData[6:0]
                : pcHighLatch;

    // Pointer write-back; relative mode leaves pointers alone.
    wire updPtr0 = isIndUpd && !indSel;
    wire updPtr1 = isIndUpd &&  indSel;

    wire [15:0] next_ptr0 =
        updPtr0 ? steppedPtr
      : wrP0Lo  ? {ptr0[15:8], busWrData}
      : wrP0Hi  ? {busWrData, ptr0[7:0]}
                : ptr0;

    wire [15:0] next_ptr1 =
        updPtr1 ? steppedPtr
      : wrP1Lo  ? {ptr1[15:8], busWrData}
      : wrP1Hi  ? {busWrData, ptr1[7:0]}
                : ptr1;

    // Read data multiplexer; unmapped offsets read as zero.
    logic [7:0] rdMux;
    always_comb begin
        unique case (busAddr)
            mie_pkg::REG_ACC:     rdMux = acc;
            mie_pkg::REG_BANK:    rdMux = {3'h0, bankSelect};
            mie_pkg::REG_LATCH:   rdMux = {1'h0, pcHighLatch};
            mie_pkg::REG_STATUS:  rdMux = {7'h00, zeroFlag};
            mie_pkg::REG_PTR0_LO: rdMux = ptr0[7:0];
            mie_pkg::REG_PTR0_HI: rdMux = ptr0[15:8];
            mie_pkg::REG_PTR1_LO: rdMux = ptr1[7:0];
            mie_pkg::REG_PTR1_HI: rdMux = ptr1[15:8];
            mie_pkg::REG_IND0:    rdMux = memBus.rdDataB;
            mie_pkg::REG_IND1:    rdMux = memBus.rdDataB;
            default:              rdMux = 8'h00;
        endcase
    end

    wire [7:0] next_busRdData = busRd ? rdMux : 8'h00;

    // Accumulator.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            acc <= mie_pkg::ACC_RST;
        end else begin
            acc <= next_acc;
        end
    end

    // Zero status flag.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            zeroFlag <= 1'b0;
        end else begin
            zeroFlag <= next_zeroFlag;
        end
    end

    // Bank select register.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            bankSelect <= mie_pkg::BANK_RST;
        end else begin
            bankSelect <= next_bankSelect;
        end
    end

    // Program counter high latch.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pcHighLatch <= mie_pkg::LATCH_RST;
        end else begin
            pcHighLatch <= next_pcHighLatch;
        end
    end

    // Indirect pointer 0.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ptr0 <= mie_pkg::PTR_RST;
        end else begin
            ptr0 <= next_ptr0;
        end
    end

    // Indirect pointer 1.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ptr1 <= mie_pkg::PTR_RST;
        end else begin
            ptr1 <= next_ptr1;
        end
    end

    // Bus read data, zero outside the cycle after a read.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            busRdData <= 8'h00;
        end else begin
            busRdData <= next_busRdData;
        end
    end

    // Completion pulse for a recognised instruction.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            instrDone <= 1'b0;
        end else begin
            instrDone <= isKnown;
        end
    end

    // Pulse for an instruction with an unknown opcode.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            instrIllegal <= 1'b0;
        end else begin
            instrIllegal <= instrValid && !isKnown;
        end
    end

endmodule

/* dv/mie_move_exec_properties.sv */
`timescale 1ns/1ps
module mie_move_exec_properties (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        instrValid,
    input wire logic [13:0] instrWord,
    input wire logic [3:0]  busAddr,
    input wire logic [7:0]  busWrData,
    input wire logic        busWr,
    input wire logic        busRd,
    input wire logic [7:0]  busRdData,
    input wire logic [7:0]  acc,
    input wire logic [4:0]  bankSelect,
    input wire logic [6:0]  pcHighLatch,
    input wire logic        zeroFlag,
    input wire logic        instrDone,
    input wire logic        instrIllegal
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    wire logic [3:0] op  = instrWord[13:10];
    wire logic [7:0] lit = instrWord[7:0];
    wire logic [4:0] k5  = instrWord[4:0];
    wire logic [6:0] k7  = instrWord[6:0];
    wire logic       go  = instrValid && !busWr;
    AST_LIT: assert property (go && op == mie_pkg::OP_LITERAL
        |=> acc == $past(lit) && $stable(zeroFlag)) else $error("bad lit");
    AST_BANK: assert property (go && op == mie_pkg::OP_BANK
        |=> bankSelect == $past(k5) && $stable(zeroFlag)) else $error("bad bank");
    AST_LATCH: assert property (go && op == mie_pkg::OP_LATCH
        |=> pcHighLatch == $past(k7) && $stable(zeroFlag)) else $error("bad latch");
    AST_ZERO: assert property (go && op inside {4'h1, 4'h2}
        |=> zeroFlag == (acc == 8'h00)) else $error("bad zero");
    AST_STORE: assert property (go && op == mie_pkg::OP_STORE
        |=> $stable(acc) && $stable(zeroFlag)) else $error("store moved acc");
    AST_DONE: assert property (instrValid && op inside {[4'h1:4'h6]}
        |=> instrDone && !instrIllegal) else $error("no done");
    AST_IDLE: assert property (!instrValid
        |=> !instrDone && !instrIllegal) else $error("stray done");
    AST_BANK_HOLD: assert property (!busWr && !(instrValid && op == 4'h3)
        |=> $stable(bankSelect)) else $error("bank moved");
endmodule
bind mie_move_exec mie_move_exec_properties chk (.sys_clk, .reset,
    .instrValid, .instrWord, .busAddr, .busWrData, .busWr, .busRd,
    .busRdData, .acc, .bankSelect, .pcHighLatch, .zeroFlag, .instrDone,
    .instrIllegal);

/* dv/test_mie_move_exec.sv */
`timescale 1ns/1ps
module test_mie_move_exec;
    logic        sys_clk    = 1'b0;
    logic        reset      = 1'b1;
    logic        instrValid = 1'b0;
    logic [13:0] instrWord  = 14'h0000;
    logic [3:0]  busAddr    = 4'h0;
    logic [7:0]  busWrData  = 8'h00;
    logic        busWr      = 1'b0;
    logic        busRd      = 1'b0;
    logic [7:0]  busRdData, acc;
    logic [4:0]  bankSelect;
    logic [6:0]  pcHighLatch;
    logic        zeroFlag, instrDone, instrIllegal;
    int          fails = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [7:0]  mem [256];
    mie_move_exec uut (.sys_clk, .reset, .instrValid, .instrWord, .busAddr,
        .busWrData, .busWr, .busRd, .busRdData, .acc, .bankSelect,
        .pcHighLatch, .zeroFlag, .instrDone, .instrIllegal);
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            end_of_test();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic bw(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        busWr <= 1'b1;
        busAddr <= a;
        busWrData <= d;
        @(posedge sys_clk);
        busWr <= 1'b0;
    endtask
    task automatic br(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        busRd <= 1'b1;
        busAddr <= a;
        @(posedge sys_clk);
        busRd <= 1'b0;
        #1 d = busRdData;
    endtask
    task automatic ex(input logic [13:0] w);
        logic [1:0] f;
        f = (w[13:10] inside {[4'h1:4'h6]}) ? 2'b01 : 2'b10;
        @(posedge sys_clk);
        instrValid <= 1'b1;
        instrWord <= w;
        @(posedge sys_clk);
        instrValid <= 1'b0;
        #1 check({instrIllegal, instrDone}, f);
    endtask
    task automatic setPtr(input logic [3:0] lo, input logic [15:0] v);
        bw(lo, v[7:0]);
        bw(lo + 4'h1, v[15:8]);
    endtask
    task automatic memPut(input logic [7:0] a, input logic [7:0] d);
        setPtr(mie_pkg::REG_PTR0_LO, {8'h00, a});
        bw(mie_pkg::REG_IND0, d);
        mem[a] = d;
    endtask
    task automatic chkPtr(input logic [3:0] lo, input logic [15:0] exp);
        logic [7:0] l, h;
        br(lo, l);
        br(lo + 4'h1, h);
        check({h, l}, exp);
    endtask
    task automatic t_literal;
        logic z;
        z = zeroFlag;
        for (int i = 0; i < 3; i++) begin
            ex({4'h5, 2'b11, 8'(i * 8'h5A)});
            check(acc, 8'(i * 8'h5A));
            check(zeroFlag, z);
        end
    endtask
    task automatic t_bank_latch;
        logic z;
        z = zeroFlag;
        for (int i = 0; i < 2; i++) begin
            ex({4'h3, 5'h00, i ? 5'h1F : 5'h00});
            check(bankSelect, i ? 5'h1F : 5'h00);
            ex({4'h4, 3'h0, i ? 7'h7F : 7'h00});
            check(pcHighLatch, i ? 7'h7F : 7'h00);
            check(zeroFlag, z);
        end
    endtask
    task automatic t_modes;
        logic [15:0] p, s, ea;
        memPut(8'h00, 8'h00);
        memPut(8'hFF, 8'h33);
        p = 16'hFFFF;
        setPtr(mie_pkg::REG_PTR1_LO, p);
        for (int m = 0; m < 4; m++) begin
            s = m[0] ? 16'hFFFF : 16'h0001;
            ea = m[1] ? p : p + s;
            p = p + s;
            ex({4'h1, 7'h00, 1'b1, 2'(m)});
            check(acc, mem[ea[7:0]]);
            check(zeroFlag, mem[ea[7:0]] == 8'h00);
            chkPtr(mie_pkg::REG_PTR1_LO, p);
        end
    endtask
    task automatic t_relative;
        logic [5:0]  o;
        logic [15:0] ea;
        memPut(8'hF0, 8'h77);
        memPut(8'h2F, 8'h88);
        setPtr(mie_pkg::REG_PTR0_LO, 16'h0010);
        for (int i = 0; i < 2; i++) begin
            o = i ? 6'h1F : 6'h20;
            ea = 16'h0010 + {{10{o[5]}}, o};
            ex({4'h2, 3'h0, 1'b0, o});
            check(acc, mem[ea[7:0]]);
            chkPtr(mie_pkg::REG_PTR0_LO, 16'h0010);
        end
    endtask
    task automatic t_store;
        logic [7:0] d;
        logic       z;
        z = zeroFlag;
        ex({4'h5, 2'b00, 8'h5A});
        ex({4'h3, 5'h00, 5'h01});
        ex({4'h6, 3'h0, 7'h20});
        ex({4'h6, 3'h0, mie_pkg::FILE_IND1});
        ex(14'h3C00);
        check(acc, 8'h5A);
        check(zeroFlag, z);
        setPtr(mie_pkg::REG_PTR0_LO, 16'h12A0);
        br(mie_pkg::REG_IND0, d);
        check(d, 8'h5A);
        br(mie_pkg::REG_IND1, d);
        check(d, 8'h5A);
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        t_literal();
        t_bank_latch();
        t_modes();
        t_relative();
        t_store();
        end_of_test();
    end
endmodule
